/* File: inc/tkc_pkg.sv */
// Constants and carrier types for the touch key counter control block
package tkc_pkg;
   // ==========================================================
   // Shared register byte addresses
   localparam logic [7:0] TKC_ADR_PRELOAD = 8'h00;
   localparam logic [7:0] TKC_ADR_CTRL_A = 8'h04;
   localparam logic [7:0] TKC_ADR_FREQ = 8'h08;
   localparam logic [7:0] TKC_ADR_CAL_LO = 8'h0c;
   localparam logic [7:0] TKC_ADR_CAL_HI = 8'h10;
   localparam logic [7:0] TKC_ADR_STATUS = 8'h14;
   // ==========================================================
   // Module blocks: block index is adr[7:5], word is adr[4:2]
   localparam logic [2:0] TKC_BLK_SHARED = 3'h0;
   localparam logic [2:0] TKC_BLK_MOD0 = 3'h1;
   localparam logic [2:0] TKC_MREG_CYC_LO = 3'h0;
   localparam logic [2:0] TKC_MREG_CYC_HI = 3'h1;
   localparam logic [2:0] TKC_MREG_REF_LO = 3'h2;
   localparam logic [2:0] TKC_MREG_REF_HI = 3'h3;
   localparam logic [2:0] TKC_MREG_CTL_A = 3'h4;
   localparam logic [2:0] TKC_MREG_CTL_B = 3'h5;
   // ==========================================================
   // Field positions
   localparam int TKC_BIT_SLOT_OVF = 6;
   localparam int TKC_BIT_START = 5;
   localparam int TKC_BIT_CYC_OVF = 4;
   localparam int TKC_BIT_CAL_OVF = 3;
   localparam int TKC_BIT_SHARED = 2;
   localparam int TKC_BIT_IRQ = 0;
   localparam int TKC_BIT_AUTO = 1;
   localparam int TKC_BIT_HOP_SRC = 3;
   localparam int TKC_BIT_SLOT_SRC = 7;
   // ==========================================================
   // Reset values and counter limits
   localparam logic [1:0] TKC_FREQ_RST = 2'h3;
   localparam logic [4:0] TKC_UNIT_LAST = 5'h1f;
   localparam logic [7:0] TKC_SLOT_LAST = 8'hff;
   localparam logic [15:0] TKC_CNT_LAST = 16'hffff;
   localparam logic [1:0] TKC_CAL_DIV1 = 2'h0;
   localparam logic [1:0] TKC_CAL_DIV2 = 2'h1;
   localparam logic [1:0] TKC_CAL_DIV4 = 2'h2;
   localparam logic [1:0] TKC_CAL_DIV8 = 2'h3;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      TKC_ST_IDLE = 3'h1,
      TKC_ST_RUN = 3'h2,
      TKC_ST_DONE = 3'h4
   } tkc_meas_state_type;
   typedef struct packed {
      logic [15:0] cyc_cnt;
      logic [4:0] unit_cnt;
      logic [7:0] slot_cnt;
      logic [9:0] ref_cap;
      logic [7:0] ctl;
      logic slot_src;
      logic done;
      logic osc_on;
      logic [2:0] hop;
   } tkc_mod_state_type;
   typedef struct packed {
      logic osc_on;
      logic [1:0] key_mux_select;
      logic freq_double_enable;
      logic [2:0] hop_frequency;
      logic [9:0] ref_cap_value;
   } tkc_mod_out_type;
endpackage

/* File: rtl/tkc_touch_ctrl.sv */
// Touch key counter control with its Wishbone register file
`timescale 1ns/10ps
`default_nettype none
module tkc_touch_ctrl #(
   parameter int NUM_MOD = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Oscillator edges, one-cycle pulses
   input wire logic [NUM_MOD-1:0] ref_osc_tick,
   input wire logic [NUM_MOD-1:0][3:0] key_osc_tick,
   // Auto scan memory and hardware hopping
   input wire logic [NUM_MOD-1:0][9:0] next_ref_cap,
   input wire logic [2:0] hw_hop_sel,
   // Oscillator controls and flags
   output logic [1:0] osc_frequency_select,
   output tkc_pkg::tkc_mod_out_type [NUM_MOD-1:0] mod_out,
   output logic touch_irq_flag
);
   // ==========================================================
   // State
   typedef struct packed {
      tkc_pkg::tkc_meas_state_type st;
      logic [7:0] preload;
      logic slot_ovf;
      logic start;
      logic cyc_ovf;
      logic cal_ovf;
      logic shared;
      logic [1:0] cal_sel;
      logic [1:0] freq;
      logic irq;
      logic auto_scan;
      logic [2:0] div;
      logic [15:0] cal_cnt;
      tkc_pkg::tkc_mod_state_type [NUM_MOD-1:0] m;
      logic ack;
      logic [31:0] rdata;
   } tkc_state_type;

   tkc_state_type s_q;
   tkc_state_type s_d;
   logic req;
   logic wr;
   logic [7:0] wd;
   logic [2:0] blk;
   logic [2:0] mreg;
   logic run;
   logic cal_tick;
   logic cal_wrap;
   logic start_rise;
   logic all_done;
   logic [NUM_MOD-1:0] slot_tick;
   logic [NUM_MOD-1:0] slot_hit;
   logic [NUM_MOD-1:0] stop_evt;
   logic [NUM_MOD-1:0] cyc_wrap;

   assign blk = wb_adr_i[7:5];
   assign mreg = wb_adr_i[4:2];
   assign wd = wb_dat_i[7:0];

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      req = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wr = req & wb_we_i & wb_sel_i[0];
      run = (s_q.st == tkc_pkg::TKC_ST_RUN);
      cal_tick = 1'b0;
      cal_wrap = 1'b0;
      start_rise = 1'b0;
      all_done = 1'b0;
      slot_tick = '0;
      slot_hit = '0;
      stop_evt = '0;
      cyc_wrap = '0;
      s_d.div = s_q.div + 3'h1;
      // Register writes; hardware sets below win over clears
      if (wr && blk == tkc_pkg::TKC_BLK_SHARED) begin
         unique case (wb_adr_i)
            tkc_pkg::TKC_ADR_PRELOAD: s_d.preload = wd;
            tkc_pkg::TKC_ADR_CTRL_A: begin
               s_d.slot_ovf = s_q.slot_ovf & wd[tkc_pkg::TKC_BIT_SLOT_OVF];
               s_d.start = wd[tkc_pkg::TKC_BIT_START];
               s_d.cyc_ovf = s_q.cyc_ovf & wd[tkc_pkg::TKC_BIT_CYC_OVF];
               s_d.cal_ovf = s_q.cal_ovf & wd[tkc_pkg::TKC_BIT_CAL_OVF];
               s_d.shared = wd[tkc_pkg::TKC_BIT_SHARED];
               s_d.cal_sel = wd[1:0];
            end
            tkc_pkg::TKC_ADR_FREQ: s_d.freq = wd[1:0];
            tkc_pkg::TKC_ADR_STATUS: begin
               s_d.irq = s_q.irq & wd[tkc_pkg::TKC_BIT_IRQ];
               s_d.auto_scan = wd[tkc_pkg::TKC_BIT_AUTO];
            end
            default: ;
         endcase
      end
      for (int i = 0; i < NUM_MOD; i++) begin
         if (wr && blk == tkc_pkg::TKC_BLK_MOD0 + 3'(i)) begin
            unique case (mreg)
               tkc_pkg::TKC_MREG_REF_LO: s_d.m[i].ref_cap[7:0] = wd;
               tkc_pkg::TKC_MREG_REF_HI: s_d.m[i].ref_cap[9:8] = wd[1:0];
               tkc_pkg::TKC_MREG_CTL_A: s_d.m[i].ctl = wd;
               tkc_pkg::TKC_MREG_CTL_B: s_d.m[i].slot_src = wd[tkc_pkg::TKC_BIT_SLOT_SRC];
               default: ;
            endcase
         end
      end
      // Calibration counter clock select
      unique case (s_q.cal_sel)
         tkc_pkg::TKC_CAL_DIV1: cal_tick = 1'b1;
         tkc_pkg::TKC_CAL_DIV2: cal_tick = s_q.div[0];
         tkc_pkg::TKC_CAL_DIV4: cal_tick = &s_q.div[1:0];
         tkc_pkg::TKC_CAL_DIV8: cal_tick = &s_q.div;
      endcase
      if (run && cal_tick) begin
         s_d.cal_cnt = s_q.cal_cnt + 16'h0001;
         if (s_q.cal_cnt == tkc_pkg::TKC_CNT_LAST) begin
            cal_wrap = 1'b1;
            s_d.cal_ovf = 1'b1;
         end
      end
      // Slot timers
      for (int i = 0; i < NUM_MOD; i++) begin
         slot_tick[i] = s_q.m[i].slot_src ? &s_q.div[1:0] : ref_osc_tick[i];
         slot_hit[i] = run && !s_q.m[i].done && slot_tick[i]
            && s_q.m[i].unit_cnt == tkc_pkg::TKC_UNIT_LAST
            && s_q.m[i].slot_cnt == tkc_pkg::TKC_SLOT_LAST;
      end
      for (int i = 0; i < NUM_MOD; i++) begin
         stop_evt[i] = s_q.shared ? slot_hit[0] : slot_hit[i];
         if (run && !s_q.m[i].done) begin
            if (key_osc_tick[i][s_q.m[i].ctl[7:6]]) begin
               s_d.m[i].cyc_cnt = s_q.m[i].cyc_cnt + 16'h0001;
               if (s_q.m[i].cyc_cnt == tkc_pkg::TKC_CNT_LAST) begin
                  cyc_wrap[i] = 1'b1;
                  s_d.cyc_ovf = 1'b1;
               end
            end
            if (slot_tick[i]) begin
               s_d.m[i].unit_cnt = s_q.m[i].unit_cnt + 5'h01;
               if (s_q.m[i].unit_cnt == tkc_pkg::TKC_UNIT_LAST) begin
                  s_d.m[i].slot_cnt = s_q.m[i].slot_cnt + 8'h01;
               end
            end
            if (stop_evt[i]) begin
               s_d.m[i].done = 1'b1;
               if (s_q.auto_scan) begin
                  s_d.m[i].ref_cap = next_ref_cap[i];
               end
            end
         end
      end
      all_done = 1'b1;
      for (int i = 0; i < NUM_MOD; i++) begin
         all_done = all_done & s_d.m[i].done;
      end
      if (run && all_done) begin
         s_d.st = tkc_pkg::TKC_ST_DONE;
         s_d.slot_ovf = 1'b1;
         s_d.irq = 1'b1;
      end
      // Measure start edges
      start_rise = s_d.start & ~s_q.start;
      if (!s_d.start) begin
         s_d.st = tkc_pkg::TKC_ST_IDLE;
         s_d.cal_cnt = '0;
         for (int i = 0; i < NUM_MOD; i++) begin
            s_d.m[i].cyc_cnt = '0;
            s_d.m[i].unit_cnt = '0;
            s_d.m[i].done = 1'b0;
         end
      end else if (start_rise) begin
         s_d.st = tkc_pkg::TKC_ST_RUN;
         for (int i = 0; i < NUM_MOD; i++) begin
            s_d.m[i].slot_cnt = s_q.preload;
            s_d.m[i].done = 1'b0;
         end
      end
      for (int i = 0; i < NUM_MOD; i++) begin
         s_d.m[i].osc_on = (s_d.st == tkc_pkg::TKC_ST_RUN) && !s_d.m[i].done;
         s_d.m[i].hop = s_d.m[i].ctl[tkc_pkg::TKC_BIT_HOP_SRC] ? hw_hop_sel
            : s_d.m[i].ctl[2:0];
      end
      // Bus answer, one cycle after the request
      s_d.ack = req;
      s_d.rdata = '0;
      if (req && !wb_we_i) begin
         if (blk == tkc_pkg::TKC_BLK_SHARED) begin
            unique case (wb_adr_i)
               tkc_pkg::TKC_ADR_PRELOAD: s_d.rdata[7:0] = s_q.preload;
               tkc_pkg::TKC_ADR_CTRL_A: s_d.rdata[7:0] = {1'b0, s_q.slot_ovf, s_q.start,
                  s_q.cyc_ovf, s_q.cal_ovf, s_q.shared, s_q.cal_sel};
               tkc_pkg::TKC_ADR_FREQ: s_d.rdata[7:0] = {6'h00, s_q.freq};
               tkc_pkg::TKC_ADR_CAL_LO: s_d.rdata[7:0] = s_q.start ? s_q.cal_cnt[7:0] : 8'h00;
               tkc_pkg::TKC_ADR_CAL_HI: s_d.rdata[7:0] = s_q.start ? s_q.cal_cnt[15:8] : 8'h00;
               tkc_pkg::TKC_ADR_STATUS: s_d.rdata[7:0] = {6'h00, s_q.auto_scan, s_q.irq};
               default: ;
            endcase
         end
         for (int i = 0; i < NUM_MOD; i++) begin
            if (blk == tkc_pkg::TKC_BLK_MOD0 + 3'(i)) begin
               unique case (mreg)
                  tkc_pkg::TKC_MREG_CYC_LO:
                     s_d.rdata[7:0] = s_q.start ? s_q.m[i].cyc_cnt[7:0] : 8'h00;
                  tkc_pkg::TKC_MREG_CYC_HI:
                     s_d.rdata[7:0] = s_q.start ? s_q.m[i].cyc_cnt[15:8] : 8'h00;
                  tkc_pkg::TKC_MREG_REF_LO: s_d.rdata[7:0] = s_q.m[i].ref_cap[7:0];
                  tkc_pkg::TKC_MREG_REF_HI: s_d.rdata[7:0] = {6'h00, s_q.m[i].ref_cap[9:8]};
                  tkc_pkg::TKC_MREG_CTL_A: s_d.rdata[7:0] = s_q.m[i].ctl;
                  tkc_pkg::TKC_MREG_CTL_B: s_d.rdata[7:0] = {s_q.m[i].slot_src, 7'h00};
                  default: ;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.st <= tkc_pkg::TKC_ST_IDLE;
         s_q.freq <= tkc_pkg::TKC_FREQ_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdata;
   assign osc_frequency_select = s_q.freq;
   assign touch_irq_flag = s_q.irq;
   for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
      assign mod_out[g].osc_on = s_q.m[g].osc_on;
      assign mod_out[g].key_mux_select = s_q.m[g].ctl[7:6];
      assign mod_out[g].freq_double_enable = s_q.m[g].ctl[5];
      assign mod_out[g].hop_frequency = s_q.m[g].hop;
      assign mod_out[g].ref_cap_value = s_q.m[g].ref_cap;
   end

   // ==========================================================
   // Assertions
   a_cyc_ovf_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
      cyc_wrap[0] |=> s_q.cyc_ovf && s_q.m[0].cyc_cnt == 16'h0000)
      else $error("cycle counter wrap did not set its flag");
   a_cal_ovf_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
      cal_wrap |=> s_q.cal_ovf && s_q.cal_cnt == 16'h0000)
      else $error("calibration counter wrap did not set its flag");
   a_cal_hold_done: assert property (@(posedge core_clk) disable iff (!resetn)
      (s_q.st == tkc_pkg::TKC_ST_DONE && s_q.start) ##1 s_q.start |-> $stable(s_q.cal_cnt))
      else $error("calibration counter moved after slot overflow");
   a_cyc_hold_done: assert property (@(posedge core_clk) disable iff (!resetn)
      (s_q.m[0].done && s_q.start) ##1 s_q.start |-> $stable(s_q.m[0].cyc_cnt))
      else $error("cycle counter moved after slot overflow");
   a_zero_when_stop: assert property (@(posedge core_clk) disable iff (!resetn)
      (!s_q.start && !start_rise) |=> s_q.cal_cnt == 16'h0000 && s_q.m[0].cyc_cnt == 16'h0000)
      else $error("counter not cleared while start is low");
   a_start_runs: assert property (@(posedge core_clk) disable iff (!resetn)
      start_rise |=> s_q.st == tkc_pkg::TKC_ST_RUN && mod_out[0].osc_on
         && s_q.m[0].slot_cnt == $past(s_q.preload))
      else $error("start edge did not switch counters on");
   a_slot_end_flags: assert property (@(posedge core_clk) disable iff (!resetn)
      (run && all_done && s_d.start) |=> s_q.slot_ovf && s_q.irq && !mod_out[0].osc_on)
      else $error("slot overflow did not set flags and stop");
   a_hop_source: assert property (@(posedge core_clk) disable iff (!resetn)
      s_q.m[0].ctl[tkc_pkg::TKC_BIT_HOP_SRC] ##1 $stable(s_q.m[0].ctl)
         |-> mod_out[0].hop_frequency == $past(hw_hop_sel))
      else $error("hardware hopping not followed");
   a_wb_ack_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_shared_stop: assert property (@(posedge core_clk) disable iff (!resetn)
      (s_q.shared && slot_hit[0]) |-> stop_evt[NUM_MOD-1])
      else $error("shared slot timer did not stop every module");
endmodule // tkc_touch_ctrl
`default_nettype wire

/* File: verif/tb_touch_key_counter_control.sv */
// Self-checking bench for the touch key counter control block
`timescale 1ns/10ps
`default_nettype none
module tb_touch_key_counter_control;
   typedef struct packed {
      logic [15:0] exp;
      logic [15:0] tol;
      logic [1:0] kind;
   } tkc_note_type;
   logic core_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, touch_irq_flag;
   logic [7:0] wb_adr_i, v, ref_per, key_per;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, got;
   logic [4:0] ref_osc_tick, osc_on, dbl;
   logic [4:0][3:0] key_osc_tick;
   logic [4:0][9:0] next_ref_cap;
   logic [2:0] hw_hop_sel;
   logic [1:0] osc_frequency_select;
   logic [15:0] lfsr, lo_b;
   tkc_pkg::tkc_mod_out_type [4:0] mod_out;
   tkc_note_type notes[$];
   tkc_note_type nt;
   int failures, n_checks, cycles;
   // =====
   // Clock and instances
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   tkc_touch_ctrl #(.NUM_MOD(5)) uut (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_osc_tick, .key_osc_tick,
      .next_ref_cap, .hw_hop_sel, .osc_frequency_select, .mod_out, .touch_irq_flag);
   tkc_pad_model #(.NUM_MOD(5)) pads (.core_clk, .resetn, .osc_on, .dbl, .ref_per, .key_per,
      .ref_osc_tick, .key_osc_tick);
   always_comb begin
      for (int n = 0; n < 5; n++) begin
         osc_on[n] = mod_out[n].osc_on;
         dbl[n] = mod_out[n].freq_double_enable;
      end
   end
   // =====
   // Tasks
   function automatic logic [15:0] rnd(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic fail(input string m);
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      n_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int w;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= s;
      w = 0;
      do begin
         @(posedge core_clk);
         w++;
      end while (wb_ack_o !== 1'b1 && w < 20);
      if (w >= 20) fail("no bus answer");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] t,
      input logic [1:0] k);
      notes.push_back('{e, t, k});
      wb(1'b0, a, 8'h00, 4'hf);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e, input logic [15:0] t);
      rd(a, 16'h0, 16'h0, 2'h1);
      rd(a + 8'h04, e, t, 2'h2);
   endtask
   task automatic measure(input logic [7:0] c, input logic aut, input logic [15:0] e);
      int w;
      wr(8'h14, {6'h0, aut, 1'b0});
      wr(8'h04, c);
      wr(8'h04, c | 8'h20);
      repeat (2) @(posedge core_clk);
      chk(16'(osc_on), 16'h1f, "oscillators off");
      w = 0;
      while (touch_irq_flag !== 1'b1 && w < 90000) begin
         @(posedge core_clk);
         w++;
      end
      if (w >= 90000) fail("measurement never ended");
      repeat (100) @(posedge core_clk);
      chk(16'(osc_on), 16'h0, "oscillators on");
      rd16(8'h0c, e, 16'h4);
   endtask
   task automatic report_and_stop;
      $display("TB: checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =====
   // Read result watcher and timeout
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 99000) begin
         failures++;
         report_and_stop();
      end
      if (wb_cyc_i && !wb_we_i && wb_ack_o === 1'b1) begin
         if (notes.size() == 0) begin
            fail("unexpected read");
         end else begin
            nt = notes.pop_front();
            if (nt.kind == 2'h1) begin
               lo_b = {8'h00, wb_dat_o[7:0]};
            end else begin
               got = (nt.kind == 2'h2) ? {16'h0, wb_dat_o[7:0], lo_b[7:0]} : wb_dat_o;
               n_checks++;
               if (^got === 1'bx || got > nt.exp + nt.tol || got + nt.tol < nt.exp)
                  fail($sformatf("read %0h want %0h", got, nt.exp));
            end
         end
      end
   end
   // =====
   // Main sequence
   initial begin
      resetn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      next_ref_cap = '0;
      hw_hop_sel = 3'h0;
      ref_per = 8'd5;
      key_per = 8'd4;
      lfsr = 16'd34201;
      failures = 0;
      n_checks = 0;
      cycles = 0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      rd(8'h08, 16'h3, 16'h0, 2'h0);
      rd(8'h04, 16'h0, 16'h0, 2'h0);
      rd(8'h18, 16'h0, 16'h0, 2'h0);
      rd16(8'h0c, 16'h0, 16'h0);
      for (int c = 0; c < 4; c++) begin
         wr(8'h08, {6'h3f, 2'(c)});
         wb(1'b1, 8'h08, 8'h00, 4'h0);
         rd(8'h08, 16'(c), 16'h0, 2'h0);
         chk(16'(osc_frequency_select), 16'(c), "frequency select");
      end
      for (int n = 0; n < 5; n++) begin
         for (int c = 0; c < 4; c++) begin
            lfsr = rnd(lfsr);
            v = {2'(c), lfsr[5], 1'b0, lfsr[3:0]};
            wr(8'h30 + 8'(n) * 8'h20, v);
            hw_hop_sel <= lfsr[10:8];
            repeat (2) @(posedge core_clk);
            chk(16'(mod_out[n].key_mux_select), 16'(c), "key mux");
            chk(16'(mod_out[n].freq_double_enable), 16'(v[5]), "doubling");
            chk(16'(mod_out[n].hop_frequency), 16'(v[3] ? lfsr[10:8] : v[2:0]), "hop");
         end
         wr(8'h28 + 8'(n) * 8'h20, lfsr[7:0]);
         wr(8'h2c + 8'(n) * 8'h20, {6'h3f, lfsr[9:8]});
         @(posedge core_clk);
         chk(16'(mod_out[n].ref_cap_value), 16'(lfsr[9:0]), "capacitor");
         rd(8'h2c + 8'(n) * 8'h20, 16'(lfsr[9:8]), 16'h0, 2'h0);
         next_ref_cap[n] <= lfsr[15:6];
         wr(8'h34 + 8'(n) * 8'h20, 8'h80);
      end
      wr(8'h30, 8'h00);
      wr(8'h50, 8'hc0);
      wr(8'h70, 8'h20);
      wr(8'h00, 8'hfe);
      for (int c = 0; c < 4; c++) begin
         measure(8'h04 | 8'(c), 1'b0, 16'd256 >> c);
      end
      rd16(8'h20, 16'd64, 16'h3);
      rd16(8'h40, 16'd36, 16'h3);
      rd16(8'h60, 16'd128, 16'h3);
      wr(8'h04, 8'h04);
      rd16(8'h20, 16'h0, 16'h0);
      for (int n = 1; n < 5; n++) begin
         wr(8'h34 + 8'(n) * 8'h20, 8'h00);
      end
      measure(8'h04, 1'b0, 16'd256);
      measure(8'h00, 1'b1, 16'd320);
      for (int n = 0; n < 5; n++) begin
         chk(16'(mod_out[n].ref_cap_value), 16'(next_ref_cap[n]), "auto reload");
      end
      wr(8'h00, 8'h00);
      wr(8'h34, 8'h00);
      ref_per <= 8'd9;
      key_per <= 8'd1;
      measure(8'h04, 1'b0, 16'd8192);
      rd16(8'h20, 16'd8192, 16'h4);
      rd(8'h04, 16'h7c, 16'h0, 2'h0);
      wr(8'h04, 8'h7c);
      rd(8'h04, 16'h7c, 16'h0, 2'h0);
      wr(8'h04, 8'h24);
      rd(8'h04, 16'h24, 16'h0, 2'h0);
      report_and_stop();
   end
endmodule // tb_touch_key_counter_control
`default_nettype wire

/* File: verif/tkc_pad_model.sv */
// Behavioural touch pad oscillators feeding the counter control block
`timescale 1ns/10ps
`default_nettype none
module tkc_pad_model #(
   parameter int NUM_MOD = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Oscillator controls, periods in clock cycles
   input wire logic [NUM_MOD-1:0] osc_on,
   input wire logic [NUM_MOD-1:0] dbl,
   input wire logic [7:0] ref_per,
   input wire logic [7:0] key_per,
   // Oscillator edges
   output logic [NUM_MOD-1:0] ref_osc_tick,
   output logic [NUM_MOD-1:0][3:0] key_osc_tick
);
   int rc[NUM_MOD];
   int kc[NUM_MOD][4];
   int p;
   // =====
   // Oscillators run only while switched on, else their counters are held at zero
   always @(posedge core_clk) begin
      for (int n = 0; n < NUM_MOD; n++) begin
         rc[n] = (resetn && osc_on[n]) ? (rc[n] + 1) % int'(ref_per) : 0;
         ref_osc_tick[n] <= resetn && osc_on[n] && rc[n] == 0;
         for (int k = 0; k < 4; k++) begin
            p = dbl[n] ? (int'(key_per) + k + 1) / 2 : int'(key_per) + k;
            kc[n][k] = osc_on[n] ? (kc[n][k] + 1) % p : 0;
            key_osc_tick[n][k] <= osc_on[n] && kc[n][k] == 0;
         end
      end
   end
endmodule // tkc_pad_model
`default_nettype wire
